// ---- rtl/hmar_defines.vh ----
// Constants for the hardware monitor alarm register bank.
// Assumes inclusion by its bare name from the design file.
`ifndef HMAR_DEFINES_VH
`define HMAR_DEFINES_VH

// ============================================================
// Bank numbers and the bank select register
// ============================================================
`define HMAR_BANK_SEL_ADDR     8'h4e
`define HMAR_BANK_TEMP3        3'h2
`define HMAR_BANK_ALARM        3'h4
`define HMAR_BANK_VALUE        3'h5

// ============================================================
// Bank 2: third temperature channel
// ============================================================
`define HMAR_TEMP3_CFG_ADDR    8'h52
`define HMAR_THYST_HI_ADDR     8'h53
`define HMAR_THYST_LO_ADDR     8'h54
`define HMAR_TOVT_HI_ADDR      8'h55
`define HMAR_TOVT_LO_ADDR      8'h56
`define HMAR_TEMP3_CFG_RST     8'h00
`define HMAR_CFG_WMASK         8'h1b
`define HMAR_CFG_STOP_BIT      0
`define HMAR_CFG_MODE_BIT      1
`define HMAR_CFG_QUEUE_LSB     3
`define HMAR_CFG_QUEUE_MSB     4
`define HMAR_THYST_RST         9'h096
`define HMAR_TOVT_RST          9'h0a0
`define HMAR_LO_BYTE_BIT       7

// ============================================================
// Bank 4: alarm status, mask, tone, live status, PWM clock
// ============================================================
`define HMAR_IRQ_STAT_ADDR     8'h50
`define HMAR_IRQ_MASK_ADDR     8'h51
`define HMAR_TONE_CTRL_ADDR    8'h53
`define HMAR_LIVE_ONE_ADDR     8'h59
`define HMAR_LIVE_TWO_ADDR     8'h5a
`define HMAR_LIVE_THREE_ADDR   8'h5b
`define HMAR_PWM_SEL_ADDR      8'h5c
`define HMAR_IRQ_MASK_RST      2'h0
`define HMAR_TONE_CTRL_RST     8'h00
`define HMAR_TONE_WMASK        8'h23
`define HMAR_TONE_USER_BIT     5
`define HMAR_STBY_BIT          0
`define HMAR_BAT_BIT           1
`define HMAR_PWM_SEL_RST       8'h11
`define HMAR_PWM_SEL_WMASK     8'h77
`define HMAR_PWM_46K87         3'h0
`define HMAR_PWM_23K43         3'h1
`define HMAR_PWM_11K72         3'h2
`define HMAR_PWM_5K85          3'h3
`define HMAR_PWM_2K93          3'h4

// ============================================================
// Bank 5: value store
// ============================================================
`define HMAR_VS_FIRST          8'h50
`define HMAR_VS_LAST           8'h57
`define HMAR_VS_STBY_READ      3'h0
`define HMAR_VS_BAT_READ       3'h1
`define HMAR_VS_STBY_HI        3'h4
`define HMAR_VS_STBY_LO        3'h5
`define HMAR_VS_BAT_HI         3'h6
`define HMAR_VS_BAT_LO         3'h7
`define HMAR_VS_PTR_ADDR       8'h5e
`define HMAR_VS_PORT_ADDR      8'h5f
`define HMAR_VS_LIMIT_RST      8'h00

`endif

// ---- rtl/hmar_alarm_regs.v ----
// Register bank of the hardware monitor: third temperature channel,
// standby and battery alarms, live status, PWM clock select, value store.
// Assumes readings and flags arrive synchronous to CLK_I from the
// converter and fan counters, and a plain strobed register port.
//
// Behaviour
// [RQ1] Two-bit fault queue sets faults needed before the alert asserts.
// [RQ2] Config bit 1 picks comparator mode (0, default) or interrupt mode (1).
// [RQ3] Config bit 0 set stops third sensor monitoring; clearing resumes it.
// [RQ4] Config resets to 0x00; bits 7 to 5 and 2 read zero.
// [RQ5] Hysteresis is nine bits: high byte bits 8-1, low byte bit 7; here low byte writes are ignored and bit 0 stays zero.
// [RQ6] Hysteresis defaults to 75 degrees Celsius.
// [RQ7] Over-temperature limit nine bits; low byte bit 7 writable, rest zero.
// [RQ8] Over-temperature limit defaults to 80 degrees Celsius.
// [RQ9] Interrupt status bit 1 flags battery excursion, bit 0 standby rail.
// [RQ10] Mask bits 1 and 0 block matching status from interrupt; reset zero.
// [RQ11] User tone bit 5 forces the alarm tone on continuously.
// [RQ12] Tone enables bits 1 and 0 let battery or standby excursions sound.
// [RQ13] Live status one shows fan, temperature and voltage over-limit flags.
// [RQ14] Live status two shows temp3, chassis, fan3, negative and +12V flags.
// [RQ15] Live status three shows battery bit 1, standby bit 0; resets zero.
// [RQ16] PWM 3 clock select encodes five frequencies, default 23.43 kHz.
// [RQ17] Bits 6-4 select PWM 4 clock with same encoding; 7, 3 reserved.
// [RQ18] Value store index auto-increments over readings and limits.
// [RQ19] Comparator alert tracks limit and hysteresis; interrupt one latches.
// [RQ20] Management interrupt asserts while any unmasked status bit is set.
//
// Decided for this implementation: the plain strobed port.

`timescale 1ns/1ns
`include "hmar_defines.vh"

module hmar_alarm_regs (
    input  wire       CLK_I,
    input  wire       RSTN_I,
    input  wire [7:0] ADDR_I,
    input  wire [7:0] WDATA_I,
    input  wire       WR_I,
    input  wire       RD_I,
    output reg  [7:0] RDATA_O,
    input  wire [8:0] TEMP3_I,
    input  wire       TEMP3_VALID_I,
    input  wire [7:0] STBY_READING_I,
    input  wire [7:0] BAT_READING_I,
    input  wire [7:0] LIVE_ONE_FLAGS_I,
    input  wire [4:0] LIVE_TWO_FLAGS_I,
    output reg        OVERTEMP_ALERT_N_O,
    output reg        SYSTEM_MGMT_IRQ_N_O,
    output reg        ALARM_TONE_O,
    output reg  [2:0] PWM_OUTPUT_THREE_SEL_O,
    output reg  [2:0] PWM_OUTPUT_FOUR_SEL_O
);

    // ============================================================
    // Register state
    // ============================================================
    reg  [2:0] bank_r;
    reg  [7:0] cfg_r;
    reg  [8:0] thyst_r;
    reg  [8:0] tovt_r;
    reg  [1:0] irq_stat_r;
    reg  [1:0] irq_mask_r;
    reg  [7:0] tone_r;
    reg  [7:0] pwm_sel_r;
    reg  [7:0] live_one_r;
    reg  [4:0] live_two_r;
    reg        temp3_over_r;
    reg  [1:0] live_three_r;
    reg  [2:0] fault_cnt_r;
    reg  [7:0] stby_hi_r;
    reg  [7:0] stby_lo_r;
    reg  [7:0] bat_hi_r;
    reg  [7:0] bat_lo_r;
    reg  [2:0] vs_ptr_r;

    // ============================================================
    // Access decode
    // ============================================================
    wire bank_temp3 = (bank_r == `HMAR_BANK_TEMP3);
    wire bank_alarm = (bank_r == `HMAR_BANK_ALARM);
    wire bank_value = (bank_r == `HMAR_BANK_VALUE);

    wire sel_bank   = (ADDR_I == `HMAR_BANK_SEL_ADDR);
    wire sel_cfg    = bank_temp3 && (ADDR_I == `HMAR_TEMP3_CFG_ADDR);
    wire sel_hy_hi  = bank_temp3 && (ADDR_I == `HMAR_THYST_HI_ADDR);
    wire sel_hy_lo  = bank_temp3 && (ADDR_I == `HMAR_THYST_LO_ADDR);
    wire sel_ov_hi  = bank_temp3 && (ADDR_I == `HMAR_TOVT_HI_ADDR);
    wire sel_ov_lo  = bank_temp3 && (ADDR_I == `HMAR_TOVT_LO_ADDR);
    wire sel_istat  = bank_alarm && (ADDR_I == `HMAR_IRQ_STAT_ADDR);
    wire sel_imask  = bank_alarm && (ADDR_I == `HMAR_IRQ_MASK_ADDR);
    wire sel_tone   = bank_alarm && (ADDR_I == `HMAR_TONE_CTRL_ADDR);
    wire sel_live1  = bank_alarm && (ADDR_I == `HMAR_LIVE_ONE_ADDR);
    wire sel_live2  = bank_alarm && (ADDR_I == `HMAR_LIVE_TWO_ADDR);
    wire sel_live3  = bank_alarm && (ADDR_I == `HMAR_LIVE_THREE_ADDR);
    wire sel_pwm    = bank_alarm && (ADDR_I == `HMAR_PWM_SEL_ADDR);
    wire sel_vs_dir = bank_value && (ADDR_I >= `HMAR_VS_FIRST)
                      && (ADDR_I <= `HMAR_VS_LAST);
    wire sel_vs_ptr = bank_value && (ADDR_I == `HMAR_VS_PTR_ADDR);
    wire sel_vs_prt = bank_value && (ADDR_I == `HMAR_VS_PORT_ADDR);

    // The data port reaches the slot under the pointer; a direct address
    // reaches its own slot.
    wire [2:0] vs_slot  = sel_vs_prt ? vs_ptr_r : ADDR_I[2:0];
    wire       vs_hit   = sel_vs_dir || sel_vs_prt;
    wire       vs_wr    = WR_I && vs_hit;

    // ============================================================
    // Value store read mux
    // ============================================================
    reg [7:0] vs_rd;
    always @* begin
        case (vs_slot)
            `HMAR_VS_STBY_READ: vs_rd = STBY_READING_I;
            `HMAR_VS_BAT_READ:  vs_rd = BAT_READING_I;
            `HMAR_VS_STBY_HI:   vs_rd = stby_hi_r;
            `HMAR_VS_STBY_LO:   vs_rd = stby_lo_r;
            `HMAR_VS_BAT_HI:    vs_rd = bat_hi_r;
            `HMAR_VS_BAT_LO:    vs_rd = bat_lo_r;
            default:            vs_rd = 8'h00;
        endcase
    end

    // ============================================================
    // Register read mux
    // ============================================================
    reg [7:0] rdata_nxt;
    always @* begin
        rdata_nxt = 8'h00;
        if (sel_bank) begin
            rdata_nxt = {5'h00, bank_r};
        end else if (sel_cfg) begin
            rdata_nxt = cfg_r & `HMAR_CFG_WMASK; // RQ4
        end else if (sel_hy_hi) begin
            rdata_nxt = thyst_r[8:1]; // RQ5
        end else if (sel_hy_lo) begin
            rdata_nxt = {thyst_r[0], 7'h00}; // RQ5
        end else if (sel_ov_hi) begin
            rdata_nxt = tovt_r[8:1]; // RQ7
        end else if (sel_ov_lo) begin
            rdata_nxt = {tovt_r[0], 7'h00}; // RQ7
        end else if (sel_istat) begin
            rdata_nxt = {6'h00, irq_stat_r};
        end else if (sel_imask) begin
            rdata_nxt = {6'h00, irq_mask_r};
        end else if (sel_tone) begin
            rdata_nxt = tone_r;
        end else if (sel_live1) begin
            rdata_nxt = live_one_r; // RQ13
        end else if (sel_live2) begin
            rdata_nxt = {2'h0, temp3_over_r, live_two_r}; // RQ14
        end else if (sel_live3) begin
            rdata_nxt = {6'h00, live_three_r}; // RQ15
        end else if (sel_pwm) begin
            rdata_nxt = pwm_sel_r;
        end else if (sel_vs_ptr) begin
            rdata_nxt = {5'h00, vs_ptr_r};
        end else if (vs_hit) begin
            rdata_nxt = vs_rd;
        end
    end

    // ============================================================
    // Limit comparators for the standby rail and the battery
    // ============================================================
    wire stby_out = (STBY_READING_I > stby_hi_r) ||
                    (STBY_READING_I < stby_lo_r);
    wire bat_out  = (BAT_READING_I > bat_hi_r) ||
                    (BAT_READING_I < bat_lo_r);
    wire [1:0] excur = {bat_out, stby_out};

    // Status bits set on each cycle an excursion stands; a read of the
    // status register clears them, but a set in that same cycle wins.
    wire [1:0] irq_clr      = (RD_I && sel_istat) ? 2'h3 : 2'h0;
    wire [1:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | excur; // RQ9

    // ============================================================
    // Third temperature channel: fault queue and alert
    // ============================================================
    wire       stop_mon  = cfg_r[`HMAR_CFG_STOP_BIT];
    wire       int_mode  = cfg_r[`HMAR_CFG_MODE_BIT];
    wire [1:0] queue     = cfg_r[`HMAR_CFG_QUEUE_MSB:`HMAR_CFG_QUEUE_LSB];
    wire [2:0] need      = {1'b0, queue} + 3'h1;
    wire       sample    = TEMP3_VALID_I && !stop_mon; // RQ3
    wire       above     = $signed(TEMP3_I) > $signed(tovt_r);
    wire       below     = $signed(TEMP3_I) < $signed(thyst_r);
    wire [2:0] fault_inc = (fault_cnt_r == 3'h7) ? fault_cnt_r :
                           fault_cnt_r + 3'h1;
    wire       trip      = sample && above && (fault_inc >= need); // RQ1

    reg [2:0] fault_cnt_nxt;
    reg       alert_nxt;
    always @* begin
        fault_cnt_nxt = fault_cnt_r;
        if (sample) begin
            fault_cnt_nxt = above ? fault_inc : 3'h0; // RQ1
        end
        alert_nxt = !OVERTEMP_ALERT_N_O;
        if (int_mode) begin
            if (RD_I && sel_live2) begin
                alert_nxt = 1'b0; // RQ19
            end
            if (trip) begin
                alert_nxt = 1'b1; // RQ2
            end
        end else begin
            if (trip) begin
                alert_nxt = 1'b1; // RQ19
            end else if (sample && below) begin
                alert_nxt = 1'b0; // RQ19
            end
        end
    end

    // ============================================================
    // Alarm tone and management interrupt
    // ============================================================
    wire tone_nxt = tone_r[`HMAR_TONE_USER_BIT] || // RQ11
                    (tone_r[`HMAR_BAT_BIT] && bat_out) || // RQ12
                    (tone_r[`HMAR_STBY_BIT] && stby_out);
    wire irq_nxt  = |(irq_stat_nxt & ~irq_mask_r); // RQ10 RQ20

    // ============================================================
    // Clocked state
    // ============================================================
    always @(posedge CLK_I) begin
        if (!RSTN_I) begin
            bank_r                 <= 3'h0;
            cfg_r                  <= `HMAR_TEMP3_CFG_RST; // RQ4
            thyst_r                <= `HMAR_THYST_RST; // RQ6
            tovt_r                 <= `HMAR_TOVT_RST; // RQ8
            irq_stat_r             <= 2'h0;
            irq_mask_r             <= `HMAR_IRQ_MASK_RST; // RQ10
            tone_r                 <= `HMAR_TONE_CTRL_RST;
            pwm_sel_r              <= `HMAR_PWM_SEL_RST; // RQ16
            live_one_r             <= 8'h00;
            live_two_r             <= 5'h00;
            temp3_over_r           <= 1'b0;
            live_three_r           <= 2'h0; // RQ15
            fault_cnt_r            <= 3'h0;
            stby_hi_r              <= `HMAR_VS_LIMIT_RST;
            stby_lo_r              <= `HMAR_VS_LIMIT_RST;
            bat_hi_r               <= `HMAR_VS_LIMIT_RST;
            bat_lo_r               <= `HMAR_VS_LIMIT_RST;
            vs_ptr_r               <= 3'h0;
            RDATA_O                <= 8'h00;
            OVERTEMP_ALERT_N_O     <= 1'b1;
            SYSTEM_MGMT_IRQ_N_O    <= 1'b1;
            ALARM_TONE_O           <= 1'b0;
            PWM_OUTPUT_THREE_SEL_O <= `HMAR_PWM_23K43;
            PWM_OUTPUT_FOUR_SEL_O  <= `HMAR_PWM_23K43;
        end else begin
            RDATA_O <= RD_I ? rdata_nxt : 8'h00;
            if (WR_I && sel_bank) begin
                bank_r <= WDATA_I[2:0];
            end
            if (WR_I && sel_cfg) begin
                cfg_r <= WDATA_I & `HMAR_CFG_WMASK; // RQ4
            end
            if (WR_I && sel_hy_hi) begin
                thyst_r[8:1] <= WDATA_I; // RQ5
            end
            if (WR_I && sel_ov_hi) begin
                tovt_r[8:1] <= WDATA_I; // RQ7
            end
            if (WR_I && sel_ov_lo) begin
                tovt_r[0] <= WDATA_I[`HMAR_LO_BYTE_BIT]; // RQ7
            end
            if (WR_I && sel_imask) begin
                irq_mask_r <= WDATA_I[1:0]; // RQ10
            end
            if (WR_I && sel_tone) begin
                tone_r <= WDATA_I & `HMAR_TONE_WMASK; // RQ11
            end
            if (WR_I && sel_pwm) begin
                pwm_sel_r <= WDATA_I & `HMAR_PWM_SEL_WMASK; // RQ17
            end
            if (WR_I && sel_vs_ptr) begin
                vs_ptr_r <= WDATA_I[2:0];
            end else if ((RD_I || WR_I) && sel_vs_prt) begin
                vs_ptr_r <= vs_ptr_r + 3'h1; // RQ18
            end
            if (vs_wr && vs_slot == `HMAR_VS_STBY_HI) begin
                stby_hi_r <= WDATA_I; // RQ18
            end
            if (vs_wr && vs_slot == `HMAR_VS_STBY_LO) begin
                stby_lo_r <= WDATA_I;
            end
            if (vs_wr && vs_slot == `HMAR_VS_BAT_HI) begin
                bat_hi_r <= WDATA_I;
            end
            if (vs_wr && vs_slot == `HMAR_VS_BAT_LO) begin
                bat_lo_r <= WDATA_I;
            end
            irq_stat_r   <= irq_stat_nxt; // RQ9
            live_one_r   <= LIVE_ONE_FLAGS_I; // RQ13
            live_two_r   <= LIVE_TWO_FLAGS_I; // RQ14
            live_three_r <= excur; // RQ15
            if (sample) begin
                temp3_over_r <= above; // RQ14
            end
            fault_cnt_r            <= fault_cnt_nxt;
            OVERTEMP_ALERT_N_O     <= !alert_nxt;
            SYSTEM_MGMT_IRQ_N_O    <= !irq_nxt; // RQ20
            ALARM_TONE_O           <= tone_nxt;
            PWM_OUTPUT_THREE_SEL_O <= pwm_sel_r[2:0]; // RQ16
            PWM_OUTPUT_FOUR_SEL_O  <= pwm_sel_r[6:4]; // RQ17
        end
    end

endmodule

// ---- dv/hmar_alarm_regs_asserts.sv ----
// Port-level checks on the alarm register bank.
// Assumes hmar_defines.vh on the include path; bound to the design below.
`timescale 1ns/1ns
`include "hmar_defines.vh"

module hmar_alarm_regs_asserts (
    input wire logic       CLK_I,
    input wire logic       RSTN_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic       TEMP3_VALID_I,
    input wire logic       OVERTEMP_ALERT_N_O,
    input wire logic       SYSTEM_MGMT_IRQ_N_O,
    input wire logic       ALARM_TONE_O,
    input wire logic [2:0] PWM_OUTPUT_THREE_SEL_O,
    input wire logic [2:0] PWM_OUTPUT_FOUR_SEL_O
);
    // ============================================================
    // Shadow copies of the control registers
    // ============================================================
    logic [2:0] bank_r;
    logic [7:0] tone_r;
    logic [1:0] mask_r;
    logic [7:0] cfg_r;
    wire        in_t3 = bank_r == `HMAR_BANK_TEMP3;
    wire        in_al = bank_r == `HMAR_BANK_ALARM;

    always @(posedge CLK_I) begin
        if (!RSTN_I) begin
            bank_r <= 3'h0;
            tone_r <= 8'h00;
            mask_r <= 2'h0;
            cfg_r <= 8'h00;
        end else if (WR_I) begin
            if (ADDR_I == `HMAR_BANK_SEL_ADDR)
                bank_r <= WDATA_I[2:0];
            if (in_al && ADDR_I == `HMAR_TONE_CTRL_ADDR)
                tone_r <= WDATA_I & `HMAR_TONE_WMASK;
            if (in_al && ADDR_I == `HMAR_IRQ_MASK_ADDR)
                mask_r <= WDATA_I[1:0];
            if (in_t3 && ADDR_I == `HMAR_TEMP3_CFG_ADDR)
                cfg_r <= WDATA_I & `HMAR_CFG_WMASK;
        end
    end

    // ============================================================
    // Properties
    // ============================================================
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    property p_reset_outs;
        $rose(RSTN_I) |-> PWM_OUTPUT_THREE_SEL_O == `HMAR_PWM_23K43 &&
            PWM_OUTPUT_FOUR_SEL_O == `HMAR_PWM_23K43 && OVERTEMP_ALERT_N_O;
    endproperty
    a_reset_outs: assert property (p_reset_outs)
        else $error("outputs wrong after reset");
    property p_pwm_hold;
        $past(RSTN_I) && !$past(WR_I) && !$past(WR_I, 2) |->
            $stable(PWM_OUTPUT_THREE_SEL_O) && $stable(PWM_OUTPUT_FOUR_SEL_O);
    endproperty
    a_pwm_hold: assert property (p_pwm_hold)
        else $error("clock select moved without a write");
    property p_user_tone; tone_r[5] |=> ALARM_TONE_O; endproperty
    a_user_tone: assert property (p_user_tone)
        else $error("forced tone not on");
    property p_tone_quiet; tone_r == 8'h00 |=> !ALARM_TONE_O; endproperty
    a_tone_quiet: assert property (p_tone_quiet)
        else $error("tone on with all enables clear");
    property p_mask_all;
        (mask_r == 2'h3) [*2] |=> SYSTEM_MGMT_IRQ_N_O;
    endproperty
    a_mask_all: assert property (p_mask_all)
        else $error("interrupt raised while fully masked");
    property p_stop_hold;
        (cfg_r[0] && !cfg_r[1]) [*3] |-> $stable(OVERTEMP_ALERT_N_O);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("alert moved while monitoring stopped");
    property p_alert_cause;
        $fell(OVERTEMP_ALERT_N_O) |-> $past(TEMP3_VALID_I) ||
            $past(TEMP3_VALID_I, 2) || $past(TEMP3_VALID_I, 3);
    endproperty
    a_alert_cause: assert property (p_alert_cause)
        else $error("alert asserted without a new sample");
    property p_cfg_read;
        RD_I && in_t3 && ADDR_I == 8'h52 |=> RDATA_O == cfg_r;
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("config read back wrong");
    property p_mask_read;
        RD_I && in_al && ADDR_I == 8'h51 |=> RDATA_O == {6'h00, mask_r};
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask read back wrong");

    c_trip: cover property ($fell(OVERTEMP_ALERT_N_O));
    c_irq: cover property ($fell(SYSTEM_MGMT_IRQ_N_O));
    c_user: cover property (tone_r[5] ##1 ALARM_TONE_O);
endmodule

bind hmar_alarm_regs hmar_alarm_regs_asserts chk_u (
    .CLK_I, .RSTN_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
    .TEMP3_VALID_I, .OVERTEMP_ALERT_N_O, .SYSTEM_MGMT_IRQ_N_O,
    .ALARM_TONE_O, .PWM_OUTPUT_THREE_SEL_O, .PWM_OUTPUT_FOUR_SEL_O
);

// ---- dv/hmar_alarm_regs_test.sv ----
// Self-checking bench for the alarm register bank, random plus corners.
// Assumes the design, its defines header and the checker are compiled.
`timescale 1ns/1ns
`include "hmar_defines.vh"

module hmar_alarm_regs_test;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       we = 1'b0;
    logic       re = 1'b0;
    logic [8:0] temp = 9'h000;
    logic       tval = 1'b0;
    logic [7:0] stby = 8'h00;
    logic [7:0] bat = 8'h00;
    logic [7:0] live1 = 8'h00;
    logic [4:0] live2 = 5'h00;
    wire  [7:0] rdata;
    wire        alert_n;
    wire        irq_n;
    wire        tone;
    wire  [2:0] pwm3;
    wire  [2:0] pwm4;
    integer     n_errors = 0;
    integer     cmp_count = 0;
    integer     i;
    integer     k;
    integer     m;
    integer     q;
    logic [7:0] v;
    logic [7:0] t;
    logic [7:0] vs[8];
    localparam logic [8:0] hot = 9'h0c8;
    localparam logic [8:0] mid = 9'h09b;
    localparam logic [8:0] cool = 9'h08c;

    always #5 clk = ~clk;

    hmar_alarm_regs dut_u (
        .CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(we), .RD_I(re), .RDATA_O(rdata), .TEMP3_I(temp),
        .TEMP3_VALID_I(tval), .STBY_READING_I(stby), .BAT_READING_I(bat),
        .LIVE_ONE_FLAGS_I(live1), .LIVE_TWO_FLAGS_I(live2),
        .OVERTEMP_ALERT_N_O(alert_n), .SYSTEM_MGMT_IRQ_N_O(irq_n),
        .ALARM_TONE_O(tone), .PWM_OUTPUT_THREE_SEL_O(pwm3),
        .PWM_OUTPUT_FOUR_SEL_O(pwm4)
    );

    // ============================================================
    // Bus and compare tasks
    // ============================================================
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task rc(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 chk(nm, e, rdata);
    endtask
    task idle(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task smp(input logic [8:0] x);
        @(posedge clk);
        temp <= x;
        tval <= 1'b1;
        @(posedge clk);
        tval <= 1'b0;
        idle(3);
    endtask
    task wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        $display("watchdog expired");
        n_errors++;
        wrap_up;
    end

    // ============================================================
    // Main sequence
    // ============================================================
    initial begin
        void'($urandom(32'h72c0));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        wr(8'h4e, 8'h02);
        rc(8'h52, 8'h00, "cfg_rst");
        rc(8'h53, 8'h4b, "hyst_hi_rst");
        rc(8'h54, 8'h00, "hyst_lo_rst");
        rc(8'h55, 8'h50, "ovt_hi_rst");
        rc(8'h56, 8'h00, "ovt_lo_rst");
        wr(8'h4e, 8'h04);
        rc(8'h51, 8'h00, "mask_rst");
        rc(8'h5b, 8'h00, "live3_rst");
        rc(8'h5c, 8'h11, "pwm_rst");
        wr(8'h5b, 8'hff);
        rc(8'h5b, 8'h00, "live3_ro");
        rc(8'h54, 8'h00, "unmapped");
        chk("irq_rst", 8'h01, irq_n);
        $display("reset test done");
        wr(8'h4e, 8'h02);
        for (i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'hff : 8'($urandom);
            wr(8'h52, v);
            rc(8'h52, v & `HMAR_CFG_WMASK, "cfg");
            wr(8'h53, v);
            rc(8'h53, v, "hyst_hi");
            wr(8'h54, v);
            rc(8'h54, 8'h00, "hyst_lo_ro");
            wr(8'h56, v);
            rc(8'h56, v & 8'h80, "ovt_lo");
        end
        wr(8'h52, 8'h00);
        wr(8'h53, 8'h4b);
        wr(8'h56, 8'h00);
        $display("threshold test done");
        wr(8'h4e, 8'h04);
        for (i = 0; i < 6; i++) begin
            v = (i < 5) ? {1'b0, 3'(4 - i), 1'b0, 3'(i)} : 8'($urandom);
            wr(8'h5c, v);
            rc(8'h5c, v & 8'h77, "pwm_sel");
            chk("pwm3", {5'h00, v[2:0]}, {5'h00, pwm3});
            chk("pwm4", {5'h00, v[6:4]}, {5'h00, pwm4});
        end
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            live1 <= 8'($urandom);
            live2 <= 5'($urandom);
            idle(3);
            rc(8'h59, live1, "live1");
            rc(8'h5a, {3'h0, live2}, "live2");
        end
        $display("pwm and live test done");
        wr(8'h4e, 8'h05);
        @(posedge clk);
        vs[0] = 8'($urandom) | 8'h01;
        vs[1] = 8'($urandom) | 8'h01;
        vs[2] = 8'h00;
        vs[3] = 8'h00;
        stby <= vs[0];
        bat <= vs[1];
        wr(8'h5e, 8'h04);
        for (i = 4; i < 8; i++) begin
            vs[i] = 8'($urandom);
            wr(8'h5f, vs[i]);
        end
        for (i = 0; i < 8; i++)
            rc(8'(8'h50 + i), vs[i], "vs_direct");
        wr(8'h5e, 8'h00);
        for (i = 0; i < 9; i++)
            rc(8'h5f, vs[i % 8], "vs_port");
        rc(8'h5e, 8'h01, "vs_ptr");
        wr(8'h5e, 8'h04);
        for (i = 0; i < 4; i++)
            wr(8'h5f, i[0] ? 8'h40 : 8'hc0);
        $display("value store test done");
        wr(8'h4e, 8'h04);
        @(posedge clk);
        stby <= 8'h80;
        bat <= 8'h80;
        idle(3);
        rc(8'h50, 8'h03, "stat_clear");
        for (m = 0; m < 4; m++) begin
            for (k = 0; k < 4; k++) begin
                t = (k == 3 && m == 3) ? 8'h20 : 8'($urandom);
                wr(8'h51, 8'(m));
                wr(8'h53, t);
                @(posedge clk);
                stby <= k[0] ? 8'hd0 : 8'h80;
                bat <= k[1] ? 8'h20 : 8'h80;
                idle(3);
                chk("irq_n", {7'h00, ~|(k[1:0] & ~m[1:0])}, irq_n);
                v = {7'h00, t[5] | (t[1] & k[1]) | (t[0] & k[0])};
                chk("tone", v, {7'h00, tone});
                rc(8'h5b, 8'(k), "live3");
                rc(8'h51, 8'(m), "mask");
                rc(8'h53, t & 8'h23, "tone_ctl");
                @(posedge clk);
                stby <= 8'h80;
                bat <= 8'h80;
                idle(3);
                rc(8'h50, 8'(k), "irq_stat");
                idle(2);
                chk("irq_idle", 8'h01, irq_n);
            end
        end
        wr(8'h53, 8'h00);
        $display("alarm test done");
        wr(8'h4e, 8'h02);
        for (q = 0; q < 4; q++) begin
            wr(8'h52, 8'(q << 3));
            repeat (q) smp(hot);
            smp(mid);
            repeat (q) smp(hot);
            chk("alert_queue", 8'h01, alert_n);
            smp(hot);
            chk("alert_trip", 8'h00, alert_n);
            smp(mid);
            chk("alert_hold", 8'h00, alert_n);
            smp(cool);
            chk("alert_clear", 8'h01, alert_n);
        end
        wr(8'h52, 8'h02);
        smp(hot);
        chk("alert_int", 8'h00, alert_n);
        smp(cool);
        chk("alert_latch", 8'h00, alert_n);
        smp(hot);
        wr(8'h4e, 8'h04);
        rc(8'h5a, {3'h1, live2}, "live2_t3");
        idle(2);
        chk("alert_ack", 8'h01, alert_n);
        wr(8'h4e, 8'h02);
        wr(8'h52, 8'h01);
        smp(hot);
        smp(hot);
        chk("alert_stop", 8'h01, alert_n);
        wr(8'h52, 8'h00);
        smp(hot);
        chk("alert_resume", 8'h00, alert_n);
        $display("temperature test done");
        wrap_up;
    end
endmodule
